/* File: rtl/arsl_defines.vh */
`ifndef ARSL_DEFINES_VH
`define ARSL_DEFINES_VH

// ---------------------------------------------------------------------
// Frame and timing constants
// ---------------------------------------------------------------------
`define ARSL_NUM_CH 2
`define ARSL_CH_W 1
`define ARSL_DATA_W 24
`define ARSL_ODR_DIV 16'h0200
`define ARSL_BARRIER_CYC 16'h0040
`define ARSL_FMT_TOGGLE 1'b1
`define ARSL_CONVERSION_READY_OUT_IDLE 1'b1

`endif

/* File: rtl/arsl_result_buf.v */
`timescale 1ns/1ps

// Per-channel conversion buffer, registered read port
module arsl_result_buf #(
    parameter NUM_CH = 2,
    parameter CH_W = 1,
    parameter DATA_W = 24
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Write side, all channels at once
    input wire wr_en,
    input wire [NUM_CH*DATA_W-1:0] wr_data,
    // Read side
    input wire [CH_W-1:0] rd_ch,
    output reg [DATA_W-1:0] rd_data
);

    reg [DATA_W-1:0] mem [0:NUM_CH-1];
    genvar g;

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : gen_ch
            // Each channel loads its slice together
            always @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    mem[g] <= {DATA_W{1'b0}};
                end else if (wr_en) begin
                    mem[g] <= wr_data[g*DATA_W +: DATA_W];
                end
            end
        end
    endgenerate

    // Registered read keeps the output glitch free
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= {DATA_W{1'b0}};
        end else begin
            rd_data <= mem[rd_ch];
        end
    end

endmodule // arsl_result_buf

/* File: rtl/arsl_readout_status.v */
`timescale 1ns/1ps
`include "arsl_defines.vh"

// Function
// R1 - With ready_pulse_format at 1 and results unread, conversion_ready_out toggles at half the output rate.
// R2 - Buffer updates drive conversion_ready_out, and unread results refresh the buffer only every second conversion.
// R3 - The host fetches data after each falling edge of conversion_ready_out so every conversion updates the buffer.
// R4 - The sync input is a running check of sample timing, never a conversion start.
// R5 - The resync flag is set again, even after clearing, whenever sync toggles out of step with the master clock.
// R6 - A result counts as read only after every channel word is read, otherwise the same data stays presented.
//      The code still refreshes an unread buffer on every second conversion.
// R7 - The host reads every word of the frame, including disabled channels.
// R8 - A write to an isolated-side configuration register sets the isolated-side fault until the barrier transfer ends.
// R9 - The host polls the isolated-side fault until it reads 0 before reading data.
module arsl_readout_status #(
    parameter NUM_CH = `ARSL_NUM_CH,
    parameter CH_W = `ARSL_CH_W,
    parameter DATA_W = `ARSL_DATA_W,
    parameter [15:0] ODR_DIV = `ARSL_ODR_DIV,
    parameter [15:0] BARRIER_CYC = `ARSL_BARRIER_CYC
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // External pins, asynchronous to clk
    input wire master_clock_input,
    input wire sync_reset_n,
    // Modulator side
    input wire [NUM_CH*DATA_W-1:0] conv_data,
    // Host frame interface, same clock domain
    input wire ready_pulse_format,
    input wire word_rd,
    input wire [CH_W-1:0] word_ch,
    input wire status_clear,
    input wire cfg_wr,
    // Results and status
    output reg [DATA_W-1:0] word_data,
    output reg conversion_ready_out,
    output reg resync_flag,
    output reg isolated_side_fault,
    output reg frame_done
);

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    reg mclk_s1, mclk_s2, mclk_s3;
    reg sync_s1, sync_s2, sync_s3;

    // Two flops before any logic looks at the pins
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mclk_s1 <= 1'b0;
            mclk_s2 <= 1'b0;
            mclk_s3 <= 1'b0;
            sync_s1 <= 1'b1;
            sync_s2 <= 1'b1;
            sync_s3 <= 1'b1;
        end else begin
            mclk_s1 <= master_clock_input;
            mclk_s2 <= mclk_s1;
            mclk_s3 <= mclk_s2;
            sync_s1 <= sync_reset_n;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
        end
    end

    wire mclk_rise = mclk_s2 & ~mclk_s3;
    wire sync_fall = ~sync_s2 & sync_s3;

    // -----------------------------------------------------------------
    // Sample period timing on master clock
    // -----------------------------------------------------------------
    reg [15:0] mclk_cnt;
    reg [15:0] next_mclk_cnt;
    reg conv_tick;
    reg resync_evt;

    // A sync edge only checks alignment; it restarts the period,
    // it does not launch an extra conversion
    always @* begin
        next_mclk_cnt = mclk_cnt;
        conv_tick = 1'b0;
        resync_evt = 1'b0;
        if (sync_fall && mclk_cnt != 16'h0000) begin
            resync_evt = 1'b1; // R5
            next_mclk_cnt = 16'h0000; // R4
        end else if (mclk_rise) begin
            if (mclk_cnt == ODR_DIV - 16'h0001) begin
                next_mclk_cnt = 16'h0000;
                conv_tick = 1'b1;
            end else begin
                next_mclk_cnt = mclk_cnt + 16'h0001;
            end
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mclk_cnt <= 16'h0000;
        end else begin
            mclk_cnt <= next_mclk_cnt;
        end
    end

    // -----------------------------------------------------------------
    // Buffer update and ready generation
    // -----------------------------------------------------------------
    reg [NUM_CH-1:0] words_seen;
    reg unread;
    reg skip_phase;
    reg buf_wr;
    wire all_read = &(words_seen | ({{(NUM_CH-1){1'b0}}, 1'b1} << word_ch)) & word_rd;
    wire [DATA_W-1:0] buf_q;

    // Unread data refreshes only on alternate conversions
    always @* begin
        buf_wr = 1'b0;
        if (conv_tick) begin
            buf_wr = ~unread | skip_phase; // R2
        end
    end

    // Track consumption of each channel word of the frame
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            words_seen <= {NUM_CH{1'b0}};
            unread <= 1'b0;
            skip_phase <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (buf_wr) begin
                words_seen <= {NUM_CH{1'b0}};
                unread <= 1'b1;
                skip_phase <= 1'b0;
            end else begin
                if (conv_tick && unread) begin
                    skip_phase <= 1'b1;
                end
                if (word_rd && unread) begin
                    if (all_read) begin
                        words_seen <= {NUM_CH{1'b0}}; // R6
                        unread <= 1'b0; // R6
                        frame_done <= 1'b1;
                    end else begin
                        words_seen <= words_seen | ({{(NUM_CH-1){1'b0}}, 1'b1} << word_ch);
                    end
                end
            end
        end
    end

    // Ready: pulse low per update, or toggle per update in format 1
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            conversion_ready_out <= `ARSL_CONVERSION_READY_OUT_IDLE;
        end else if (buf_wr) begin
            if (ready_pulse_format == `ARSL_FMT_TOGGLE) begin
                conversion_ready_out <= ~conversion_ready_out; // R1
            end else begin
                conversion_ready_out <= 1'b0; // R2
            end
        end else if (ready_pulse_format != `ARSL_FMT_TOGGLE) begin
            if (frame_done || all_read) begin
                conversion_ready_out <= 1'b1;
            end
        end
    end

    arsl_result_buf #(
        .NUM_CH(NUM_CH),
        .CH_W(CH_W),
        .DATA_W(DATA_W)
    ) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(buf_wr),
        .wr_data(conv_data),
        .rd_ch(word_ch),
        .rd_data(buf_q)
    );

    // Word data follows buffer read one cycle later
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            word_data <= {DATA_W{1'b0}};
        end else begin
            word_data <= buf_q;
        end
    end

    // -----------------------------------------------------------------
    // Status flags
    // -----------------------------------------------------------------
    reg [15:0] barrier_cnt;

    // Set beats clear so a late event is never dropped
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resync_flag <= 1'b0;
        end else if (resync_evt) begin
            resync_flag <= 1'b1; // R5
        end else if (status_clear) begin
            resync_flag <= 1'b0;
        end
    end

    // Fault holds for the barrier transfer time; a new write restarts it
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            barrier_cnt <= 16'h0000;
            isolated_side_fault <= 1'b0;
        end else if (cfg_wr) begin
            barrier_cnt <= BARRIER_CYC; // R8
            isolated_side_fault <= 1'b1; // R8
        end else if (barrier_cnt != 16'h0000) begin
            barrier_cnt <= barrier_cnt - 16'h0001;
            isolated_side_fault <= (barrier_cnt != 16'h0001);
        end else begin
            isolated_side_fault <= 1'b0;
        end
    end

endmodule // arsl_readout_status

/* File: testbench/arsl_props.sv */
`timescale 1ns/1ps

// ------
// Port checks
// ------
module arsl_props #(
    parameter [15:0] BARRIER_CYC = 16'h0040
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Inputs and results
    input wire cfg_wr,
    input wire status_clear,
    input wire sync_reset_n,
    input wire ready_pulse_format,
    input wire word_rd,
    input wire conversion_ready_out,
    input wire resync_flag,
    input wire isolated_side_fault,
    input wire frame_done
);
    reg [15:0] fcnt;
    reg [7:0] gap;
    reg rq;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Fault length since last write; spacing of ready changes
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fcnt <= 16'h0000;
            gap <= 8'h00;
            rq <= 1'b1;
        end else begin
            fcnt <= cfg_wr ? 16'h0000 : fcnt + {15'h0000, isolated_side_fault};
            gap <= (rq != conversion_ready_out) ? 8'h01 : gap + {7'h00, gap != 8'hFF};
            rq <= conversion_ready_out;
        end
    end
    fault_rise_a: assert property (cfg_wr |=> isolated_side_fault)
        else $error("fault not raised after write");
    fault_hold_a: assert property ($fell(isolated_side_fault) |-> fcnt == BARRIER_CYC)
        else $error("fault length wrong");
    fault_cause_a: assert property ($rose(isolated_side_fault) |-> $past(cfg_wr))
        else $error("fault without write");
    resync_keep_a: assert property (resync_flag && !status_clear |=> resync_flag)
        else $error("resync flag lost");
    resync_cause_a: assert property ($rose(resync_flag) |-> !$past(sync_reset_n, 2))
        else $error("resync flag without sync edge");
    done_cause_a: assert property (frame_done |-> $past(word_rd) ##1 !frame_done)
        else $error("frame done without read");
    ready_read_a: assert property ($rose(conversion_ready_out) && !ready_pulse_format |-> frame_done)
        else $error("ready rose before frame read");
    ready_rate_a: assert property ($changed(conversion_ready_out) && ready_pulse_format |-> gap > 8'h18)
        else $error("ready toggles too fast");
    cover property (cfg_wr);
    cover property ($rose(resync_flag));
    cover property (frame_done);
endmodule // arsl_props

bind arsl_readout_status arsl_props #(.BARRIER_CYC(BARRIER_CYC)) u_props (.clk(clk),
    .sys_rst(sys_rst), .cfg_wr(cfg_wr), .status_clear(status_clear),
    .sync_reset_n(sync_reset_n), .ready_pulse_format(ready_pulse_format), .word_rd(word_rd),
    .conversion_ready_out(conversion_ready_out), .resync_flag(resync_flag),
    .isolated_side_fault(isolated_side_fault), .frame_done(frame_done));

/* File: testbench/arsl_host_model.sv */
`timescale 1ns/1ps

// ------
// Host controller
// ------
module arsl_host_model (
    // Clock and control
    input wire clk,
    input wire en,
    input wire slow,
    input wire partial,
    // Device status
    input wire conversion_ready_out,
    input wire isolated_side_fault,
    // Frame reads
    output reg word_rd,
    output reg [0:0] word_ch
);
    reg last = 1'b1;
    integer i;
    // Fetch a frame after each ready fall; partial repeats one channel
    initial begin
        word_rd = 1'b0;
        word_ch = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            if (en && last && !conversion_ready_out) begin
                while (isolated_side_fault) @(posedge clk);
                if (slow) repeat (5) @(posedge clk);
                #1;
                for (i = 0; i < 2; i = i + 1) begin
                    word_rd = 1'b1;
                    word_ch = partial ? 1'b0 : i[0];
                    @(posedge clk);
                    #1;
                end
                word_rd = 1'b0;
            end
            last = conversion_ready_out;
        end
    end
endmodule // arsl_host_model

/* File: testbench/arsl_readout_status_tb_top.sv */
`timescale 1ns/1ps

// ------
// Bench top
// ------
module arsl_readout_status_tb_top;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg master_clock_input = 1'b0;
    reg sync_reset_n = 1'b1;
    reg [47:0] conv_data = 48'h0;
    reg fmt = 1'b0;
    reg status_clear = 1'b0;
    reg cfg_wr = 1'b0;
    reg host_en = 1'b0;
    reg slow = 1'b0;
    reg partial = 1'b0;
    reg [15:0] lfsr = 16'h87EC;
    reg [47:0] exp_buf = 48'h0;
    reg [1:0] rd_d = 2'h0;
    reg [1:0] ch_d = 2'h0;
    reg rdy_q = 1'b1;
    integer n_fail = 0;
    integer n_checks = 0;
    integer nframes = 0;
    integer c;
    integer n0;
    wire word_rd;
    wire [0:0] word_ch;
    wire [23:0] word_data;
    wire rdy, resync, fault, frame_done;

    function [15:0] nxt(input [15:0] v);
        nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task check(input [8*8-1:0] name, input [47:0] seen, input [47:0] want);
        begin
            n_checks = n_checks + 1;
            if (seen !== want) begin
                n_fail = n_fail + 1;
                $display("BAD %0s exp %h seen %h", name, want, seen);
            end
        end
    endtask

    task close_out;
        begin
            if (n_fail == 0 && n_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task rst_cyc;
        begin
            sys_rst <= 1'b1;
            repeat (4) @(posedge clk);
            sys_rst <= 1'b0;
        end
    endtask

    // Bounded wait for the next ready change
    task wait_chg;
        reg v;
        begin
            v = rdy;
            c = 0;
            while (rdy === v && c < 500) begin
                @(posedge clk);
                c = c + 1;
            end
        end
    endtask

    // Sync fall held low, flag sampled, then cleared; gap is fall to fall
    task sync_pulse(input integer gap, input do_chk, input [47:0] want);
        begin
            sync_reset_n <= 1'b0;
            repeat (10) @(posedge clk);
            sync_reset_n <= 1'b1;
            if (do_chk) check("resync", resync, want);
            status_clear <= 1'b1;
            @(posedge clk);
            status_clear <= 1'b0;
            repeat (gap - 11) @(posedge clk);
        end
    endtask

    initial forever #5 clk = ~clk;
    initial forever #40 master_clock_input = ~master_clock_input;

    arsl_readout_status #(.ODR_DIV(16'h0004)) dut (.clk(clk), .sys_rst(sys_rst),
        .master_clock_input(master_clock_input), .sync_reset_n(sync_reset_n),
        .conv_data(conv_data), .ready_pulse_format(fmt), .word_rd(word_rd),
        .word_ch(word_ch), .status_clear(status_clear), .cfg_wr(cfg_wr),
        .word_data(word_data), .conversion_ready_out(rdy), .resync_flag(resync),
        .isolated_side_fault(fault), .frame_done(frame_done));

    arsl_host_model host (.clk(clk), .en(host_en), .slow(slow), .partial(partial),
        .conversion_ready_out(rdy), .isolated_side_fault(fault), .word_rd(word_rd),
        .word_ch(word_ch));

    // Read data two cycles after each read; new sample after each fall
    always @(posedge clk) begin
        rd_d <= {rd_d[0], word_rd};
        ch_d <= {ch_d[0], word_ch};
        if (rd_d[1] && !fmt) check("data", word_data, ch_d[1] ? exp_buf[47:24] : exp_buf[23:0]);
        // Host must never read while the barrier transfer is still busy
        if (word_rd) check("poll", fault, 48'h0);
        if (frame_done) nframes <= nframes + 1;
        if (rdy_q && !rdy) begin
            exp_buf <= conv_data;
            conv_data <= {lfsr, ~lfsr, lfsr ^ 16'h5A5A};
            lfsr <= nxt(lfsr);
        end
        rdy_q <= rdy;
    end

    initial begin
        #100000;
        n_fail = n_fail + 1;
        close_out;
    end

    initial begin
        rst_cyc;
        host_en <= 1'b1;
        repeat (12) begin
            slow <= lfsr[3];
            repeat (32) @(posedge clk);
        end
        check("frames", {47'h0, nframes > 9}, 48'h1);
        // Config write just after a completed frame, so the next fall finds the fault busy
        while (frame_done !== 1'b1) @(posedge clk);
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        n0 = nframes;
        repeat (128) @(posedge clk);
        check("polled", {47'h0, nframes > n0}, 48'h1);
        // Let a frame already in flight finish before counting
        partial <= 1'b1;
        repeat (4) @(posedge clk);
        n0 = nframes;
        repeat (96) @(posedge clk);
        check("ready", rdy, 48'h0);
        check("nframes", nframes - n0, 48'h0);
        partial <= 1'b0;
        host_en <= 1'b0;
        fmt <= 1'b1;
        rst_cyc;
        wait_chg;
        wait_chg;
        check("period", c, 48'd64);
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        @(posedge clk);
        check("fault", fault, 48'h1);
        repeat (63) @(posedge clk);
        check("fault", fault, 48'h1);
        @(posedge clk);
        check("fault", fault, 48'h0);
        sync_pulse(77, 1'b0, 48'h0);
        sync_pulse(128, 1'b1, 48'h1);
        sync_pulse(20, 1'b1, 48'h0);
        close_out;
    end
endmodule // arsl_readout_status_tb_top
